//--- design/recpcs_pkg.sv
// package for the receive error counter and coding sublayer register bank
// assumes a serial management frame engine and a 200 MHz system clock
package recpcs_pkg;

    // ****************************************************************
    // register map and field layout
    // ****************************************************************
    localparam logic [4:0] RECPCS_ADDR_RX_ERR_CNT = 5'h15;
    localparam logic [4:0] RECPCS_ADDR_PCS_CFG = 5'h16;
    localparam int RECPCS_CNT_WIDTH = 8;
    localparam int RECPCS_BIT_FREE_CLK = 11;
    localparam int RECPCS_BIT_TRUE_QUIET = 10;
    localparam int RECPCS_BIT_FORCE_SD = 9;
    localparam int RECPCS_BIT_SIGNAL_DETECT_OPTION = 8;
    localparam int RECPCS_BIT_DESCRAMBLER_TIMEOUT_SELECT = 7;
    localparam int RECPCS_BIT_FORCE_LINK = 5;
    localparam int RECPCS_BIT_NRZI_BYP = 2;
    localparam logic [15:0] RECPCS_PCS_WR_MASK = 16'h0FA4;
    localparam logic [15:0] RECPCS_PCS_RESET = 16'h0100;

    // ****************************************************************
    // management frame codes and lengths
    // ****************************************************************
    localparam logic [1:0] RECPCS_OP_READ = 2'b10;
    localparam logic [1:0] RECPCS_OP_WRITE = 2'b01;
    localparam logic [4:0] RECPCS_HDR_BITS = 5'd13;
    localparam logic [4:0] RECPCS_TA_BITS = 5'd2;
    localparam logic [4:0] RECPCS_DATA_BITS = 5'd16;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int RECPCS_CLK_MHZ = 200;
    localparam int RECPCS_DESC_SHORT_US = 722;
    localparam int RECPCS_DESC_LONG_MS = 2;
    localparam int RECPCS_DESC_SHORT_CYC =
        RECPCS_DESC_SHORT_US * RECPCS_CLK_MHZ;
    localparam int RECPCS_DESC_LONG_CYC =
        RECPCS_DESC_LONG_MS * 1000 * RECPCS_CLK_MHZ;

    typedef enum logic [1:0] {
        RECPCS_ST_IDLE = 2'b00,
        RECPCS_ST_HDR = 2'b01,
        RECPCS_ST_TA = 2'b10,
        RECPCS_ST_DATA = 2'b11
    } recpcs_state_t;

    // coding sublayer controls handed to the datapath
    typedef struct packed {
        logic free_clk;
        logic true_quiet_enable;
        logic forced_signal_detect;
        logic signal_detect_option;
        logic descrambler_timeout_select;
        logic forced_good_link;
        logic nrzi_bypass;
    } recpcs_ctrl_t;

endpackage

//--- design/recpcs_err_cnt.sv
// saturating receive symbol error counter, qualified per carrier event
// assumes carrier, symbol error and collision come from the system clock
`timescale 1ns/1ps
`default_nettype none
module recpcs_err_cnt #(
    parameter int WIDTH = recpcs_pkg::RECPCS_CNT_WIDTH
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic carrier_i,
    input wire logic sym_err_i,
    input wire logic collision_i,
    input wire logic clear_i,
    output logic [WIDTH-1:0] count_o
);
    import recpcs_pkg::*;

    initial begin
        if (WIDTH < 1 || WIDTH > 16) begin
            $error("recpcs_err_cnt: WIDTH must be 1 to 16");
        end
    end

    logic in_carrier_q, in_carrier_d;
    logic err_seen_q, err_seen_d;
    logic col_seen_q, col_seen_d;
    logic [WIDTH-1:0] count_q, count_d;
    logic bump;

    always_comb begin
        in_carrier_d = carrier_i;
        err_seen_d = err_seen_q;
        col_seen_d = col_seen_q;
        if (carrier_i && !in_carrier_q) begin
            err_seen_d = sym_err_i;
            col_seen_d = collision_i;
        end else if (carrier_i) begin
            err_seen_d = err_seen_q | sym_err_i;
            col_seen_d = col_seen_q | collision_i;
        end
        // counted once when the carrier event ends, never per symbol
        bump = in_carrier_q && !carrier_i &&
            err_seen_q && !col_seen_q;
        count_d = count_q;
        if (clear_i) begin
            count_d = '0;
        end
        // an event landing on the clear cycle survives as a count of one
        if (bump && (clear_i || count_q != {WIDTH{1'b1}})) begin
            count_d = clear_i ? WIDTH'(1) : count_q + WIDTH'(1);
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_carrier_q <= 1'b0;
            err_seen_q <= 1'b0;
            col_seen_q <= 1'b0;
            count_q <= '0;
        end else begin
            in_carrier_q <= in_carrier_d;
            err_seen_q <= err_seen_d;
            col_seen_q <= col_seen_d;
            count_q <= count_d;
        end
    end

    assign count_o = count_q;
endmodule
`default_nettype wire

//--- design/recpcs_top.sv
// receive error counter and coding sublayer register pair behind the
// serial management pins, with the 100 Mb/s link and lock logic
// assumes management clock far slower than sys_clk (bench: 80 ns period)
`timescale 1ns/1ps
`default_nettype none
module recpcs_top #(
    parameter int DESC_SHORT_CYC = recpcs_pkg::RECPCS_DESC_SHORT_CYC,
    parameter int DESC_LONG_CYC = recpcs_pkg::RECPCS_DESC_LONG_CYC
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [4:0] phy_addr_i,
    input wire logic mgmt_clk_i,
    input wire logic mgmt_data_i,
    output logic mgmt_data_o,
    output logic mgmt_data_oe_o,
    input wire logic carrier_i,
    input wire logic rx_sym_err_i,
    input wire logic collision_i,
    input wire logic signal_level_i,
    input wire logic desc_acquire_i,
    input wire logic desc_idle_seen_i,
    output recpcs_pkg::recpcs_ctrl_t ctrl_o,
    output logic signal_detect_o,
    output logic desc_locked_o,
    output logic link_100_o
);
    import recpcs_pkg::*;

    initial begin
        if (DESC_SHORT_CYC < 1 || DESC_LONG_CYC < DESC_SHORT_CYC ||
            DESC_LONG_CYC >= (1 << 20)) begin
            $error("recpcs_top: descrambler timeout counts out of range");
        end
    end

    // ****************************************************************
    // pin synchronisers and management clock edge
    // ****************************************************************
    logic [1:0] mdc_sync_q, mdio_sync_q;
    logic mdc_prev_q;
    logic mdc_rise;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mdc_sync_q <= 2'b00;
            mdio_sync_q <= 2'b11;
            mdc_prev_q <= 1'b0;
        end else begin
            mdc_sync_q <= {mdc_sync_q[0], mgmt_clk_i};
            mdio_sync_q <= {mdio_sync_q[0], mgmt_data_i};
            mdc_prev_q <= mdc_sync_q[1];
        end
    end

    assign mdc_rise = mdc_sync_q[1] && !mdc_prev_q;

    // ****************************************************************
    // register decode
    // ****************************************************************
    function automatic logic reg_hit(input logic [4:0] a);
        reg_hit = (a == RECPCS_ADDR_RX_ERR_CNT) || (a == RECPCS_ADDR_PCS_CFG);
    endfunction

    logic [15:0] pcs_q, pcs_d;
    logic [RECPCS_CNT_WIDTH-1:0] err_count;
    logic cnt_clear;

    // ****************************************************************
    // serial management frame engine
    // ****************************************************************
    recpcs_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic [12:0] hdr_q, hdr_d;
    logic [15:0] shift_q, shift_d;
    logic oe_q, oe_d;
    logic out_q, out_d;
    logic mine;
    logic [15:0] rd_word;

    assign mine = hdr_q[12] && hdr_q[9:5] == phy_addr_i;

    always_comb begin
        rd_word = 16'h0000;
        if (hdr_q[4:0] == RECPCS_ADDR_RX_ERR_CNT) begin
            rd_word = {{(16 - RECPCS_CNT_WIDTH){1'b0}}, err_count};
        end else if (hdr_q[4:0] == RECPCS_ADDR_PCS_CFG) begin
            rd_word = pcs_q & RECPCS_PCS_WR_MASK;
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        shift_d = shift_q;
        oe_d = oe_q;
        out_d = out_q;
        pcs_d = pcs_q;
        cnt_clear = 1'b0;
        if (mdc_rise) begin
            case (state_q)
                RECPCS_ST_IDLE: begin
                    oe_d = 1'b0;
                    // the zero of the start pattern ends the preamble
                    if (!mdio_sync_q[1]) begin
                        state_d = RECPCS_ST_HDR;
                        cnt_d = 5'd0;
                    end
                end
                RECPCS_ST_HDR: begin
                    hdr_d = {hdr_q[11:0], mdio_sync_q[1]};
                    cnt_d = cnt_q + 5'd1;
                    if (cnt_q == RECPCS_HDR_BITS - 5'd1) begin
                        state_d = RECPCS_ST_TA;
                        cnt_d = 5'd0;
                    end
                end
                RECPCS_ST_TA: begin
                    cnt_d = cnt_q + 5'd1;
                    if (cnt_q == 5'd0 && mine && reg_hit(hdr_q[4:0]) &&
                        hdr_q[11:10] == RECPCS_OP_READ) begin
                        shift_d = rd_word;
                        oe_d = 1'b1;
                        out_d = 1'b0;
                        if (hdr_q[4:0] == RECPCS_ADDR_RX_ERR_CNT) begin
                            cnt_clear = 1'b1;
                        end
                    end
                    if (cnt_q == RECPCS_TA_BITS - 5'd1) begin
                        state_d = RECPCS_ST_DATA;
                        cnt_d = 5'd0;
                        if (oe_q) begin
                            out_d = shift_q[15];
                            shift_d = {shift_q[14:0], 1'b0};
                        end
                    end
                end
                RECPCS_ST_DATA: begin
                    cnt_d = cnt_q + 5'd1;
                    if (oe_q) begin
                        out_d = shift_q[15];
                        shift_d = {shift_q[14:0], 1'b0};
                    end else begin
                        shift_d = {shift_q[14:0], mdio_sync_q[1]};
                    end
                    if (cnt_q == RECPCS_DATA_BITS - 5'd1) begin
                        state_d = RECPCS_ST_IDLE;
                        oe_d = 1'b0;
                        out_d = 1'b0;
                        // counter register takes no write at all
                        if (!oe_q && mine && hdr_q[11:10] == RECPCS_OP_WRITE &&
                            hdr_q[4:0] == RECPCS_ADDR_PCS_CFG &&
                            reg_hit(hdr_q[4:0])) begin
                            pcs_d = {shift_q[14:0], mdio_sync_q[1]} &
                                RECPCS_PCS_WR_MASK;
                        end
                    end
                end
                default: begin
                    state_d = RECPCS_ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= RECPCS_ST_IDLE;
            cnt_q <= 5'd0;
            hdr_q <= 13'h0000;
            shift_q <= 16'h0000;
            oe_q <= 1'b0;
            out_q <= 1'b0;
            pcs_q <= RECPCS_PCS_RESET;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            shift_q <= shift_d;
            oe_q <= oe_d;
            out_q <= out_d;
            pcs_q <= pcs_d;
        end
    end

    assign mgmt_data_o = out_q;
    assign mgmt_data_oe_o = oe_q;

    recpcs_err_cnt #(
        .WIDTH(RECPCS_CNT_WIDTH)
    ) u_err_cnt (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .carrier_i(carrier_i),
        .sym_err_i(rx_sym_err_i),
        .collision_i(collision_i),
        .clear_i(cnt_clear),
        .count_o(err_count)
    );

    // ****************************************************************
    // coding sublayer controls
    // ****************************************************************
    always_comb begin
        ctrl_o.free_clk = pcs_q[RECPCS_BIT_FREE_CLK];
        ctrl_o.true_quiet_enable = pcs_q[RECPCS_BIT_TRUE_QUIET];
        ctrl_o.forced_signal_detect = pcs_q[RECPCS_BIT_FORCE_SD];
        ctrl_o.signal_detect_option = pcs_q[RECPCS_BIT_SIGNAL_DETECT_OPTION];
        ctrl_o.descrambler_timeout_select = pcs_q[RECPCS_BIT_DESCRAMBLER_TIMEOUT_SELECT];
        ctrl_o.forced_good_link = pcs_q[RECPCS_BIT_FORCE_LINK];
        ctrl_o.nrzi_bypass = pcs_q[RECPCS_BIT_NRZI_BYP];
    end

    // ****************************************************************
    // descrambler lock timer and 100 Mb/s link
    // ****************************************************************
    logic [19:0] tmo_q, tmo_d;
    logic lock_q, lock_d;
    logic link_q, link_d;
    logic sd;
    logic [19:0] tmo_limit;

    assign sd = pcs_q[RECPCS_BIT_FORCE_SD] | signal_level_i;
    assign tmo_limit = pcs_q[RECPCS_BIT_DESCRAMBLER_TIMEOUT_SELECT] ?
        20'(DESC_LONG_CYC) : 20'(DESC_SHORT_CYC);

    always_comb begin
        tmo_d = tmo_q;
        lock_d = lock_q;
        // lock is lost only when no idle arrives within the timeout
        if (!lock_q) begin
            lock_d = desc_acquire_i;
            tmo_d = 20'h0_0000;
        end else if (desc_idle_seen_i) begin
            tmo_d = 20'h0_0000;
        end else if (tmo_q >= tmo_limit - 20'h0_0001) begin
            lock_d = 1'b0;
            tmo_d = 20'h0_0000;
        end else begin
            tmo_d = tmo_q + 20'h0_0001;
        end
        if (!link_q) begin
            link_d = sd && lock_q;
        end else if (pcs_q[RECPCS_BIT_SIGNAL_DETECT_OPTION]) begin
            link_d = sd;
        end else begin
            link_d = sd && lock_q;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tmo_q <= 20'h0_0000;
            lock_q <= 1'b0;
            link_q <= 1'b0;
        end else begin
            tmo_q <= tmo_d;
            lock_q <= lock_d;
            link_q <= link_d;
        end
    end

    assign signal_detect_o = sd;
    assign desc_locked_o = lock_q;
    assign link_100_o = link_q | pcs_q[RECPCS_BIT_FORCE_LINK];
endmodule
`default_nettype wire

//--- testbench/recpcs_top_sva.sv
// concurrent checks on the receive error and coding sublayer block
// assumes a bind into recpcs_top; everything runs on sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module recpcs_sva (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic mgmt_data_o,
    input wire logic mgmt_data_oe_o,
    input wire logic signal_level_i,
    input wire recpcs_pkg::recpcs_ctrl_t ctrl_o,
    input wire logic signal_detect_o,
    input wire logic desc_locked_o,
    input wire logic link_100_o
);
    import recpcs_pkg::*;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // ****************
    // frame and link checks
    // ****************
    // the turnaround zero must stand while the station samples it
    sequence ta_zero_s;
        mgmt_data_oe_o && !mgmt_data_o;
    endsequence
    sequence up_no_force_s;
        link_100_o && !ctrl_o.forced_good_link;
    endsequence
    ta_zero_a: assert property (
        $rose(mgmt_data_oe_o) |-> ta_zero_s [*8])
        else $error("turnaround not driven low");
    cfg_reset_a: assert property (
        $rose(arst_n_i) |-> ctrl_o == 7'h08)
        else $error("config controls wrong after reset");
    sd_force_a: assert property (
        signal_detect_o == (ctrl_o.forced_signal_detect | signal_level_i))
        else $error("signal detect not force or level");
    good_link_a: assert property (
        ctrl_o.forced_good_link |-> link_100_o)
        else $error("forced link not reported");
    link_cause_a: assert property (
        $rose(link_100_o) && !ctrl_o.forced_good_link
        |-> $past(signal_detect_o) && $past(desc_locked_o))
        else $error("link rose without signal and lock");
    opt_hold_a: assert property (
        up_no_force_s ##0 (signal_detect_o && ctrl_o.signal_detect_option)
        |=> link_100_o)
        else $error("link lost while signal held");
    opt_drop_a: assert property (
        !ctrl_o.signal_detect_option && !desc_locked_o
        |=> !link_100_o || ctrl_o.forced_good_link)
        else $error("link kept without lock");
    sd_drop_a: assert property (
        !signal_detect_o |=> !link_100_o || ctrl_o.forced_good_link)
        else $error("link kept without signal");
endmodule
bind recpcs_top recpcs_sva i_sva (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .mgmt_data_o(mgmt_data_o), .mgmt_data_oe_o(mgmt_data_oe_o),
    .signal_level_i(signal_level_i), .ctrl_o(ctrl_o),
    .signal_detect_o(signal_detect_o), .desc_locked_o(desc_locked_o),
    .link_100_o(link_100_o)
);
`default_nettype wire

//--- testbench/recpcs_mgmt_host.sv
// management station model driving frames on the serial pins
// assumes a pull-up on the data pin; the clock idles low between frames
`timescale 1ns/1ps
`default_nettype none
module recpcs_mgmt_host (
    output logic mgmt_clk_o,
    output logic mgmt_line_o,
    input wire logic dev_data_i,
    input wire logic dev_oe_i
);
    import recpcs_pkg::*;
    logic drv_en = 1'h0;
    logic drv_bit = 1'h1;
    initial mgmt_clk_o = 1'h0;
    // a released line floats up, so a silent device reads as ones
    assign mgmt_line_o = dev_oe_i ? dev_data_i : (drv_en ? drv_bit : 1'h1);
    // ****************
    // one frame: 32 rises plus one idle rise
    // ****************
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] reg_a, input logic [15:0] wdata,
                         output logic [15:0] rdata);
        logic [31:0] bits;
        bits = {2'b01, op, phy, reg_a, 2'b10, wdata};
        rdata = 16'h0000;
        for (int i = 0; i < 33; i++) begin
            drv_en = (i < 14) || (op == RECPCS_OP_WRITE && i < 32);
            drv_bit = (i < 32) ? bits[31-i] : 1'h1;
            #40;
            if (i >= 16 && i < 32) rdata = {rdata[14:0], mgmt_line_o};
            mgmt_clk_o = 1'h1;
            #40;
            mgmt_clk_o = 1'h0;
        end
        drv_en = 1'h0;
    endtask
endmodule
`default_nettype wire

//--- testbench/recpcs_top_tb.sv
// self-checking bench for the receive error counter and config pair
// assumes the station model owns the serial pins; timeouts shortened
`timescale 1ns/1ps
`default_nettype none
module recpcs_top_tb;
    import recpcs_pkg::*;
    localparam logic [4:0] PHY = 5'h03;
    localparam logic [4:0] CNT = RECPCS_ADDR_RX_ERR_CNT;
    localparam logic [4:0] CFG = RECPCS_ADDR_PCS_CFG;
    logic sys_clk = 1'h0;
    logic arst_n = 1'h0;
    logic carrier = 1'h0;
    logic sym_err = 1'h0;
    logic collision = 1'h0;
    logic sig_level = 1'h0;
    logic acquire = 1'h0;
    logic idle_seen = 1'h0;
    logic mgmt_clk;
    logic mgmt_line;
    logic dev_data;
    logic dev_oe;
    recpcs_ctrl_t ctrl;
    logic sd;
    logic locked;
    logic link;
    logic [15:0] rd_val;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int bitpos [7] = '{2, 5, 7, 8, 9, 10, 11};
    always #2.5 sys_clk = ~sys_clk;
    recpcs_mgmt_host i_host (.mgmt_clk_o(mgmt_clk), .mgmt_line_o(mgmt_line),
        .dev_data_i(dev_data), .dev_oe_i(dev_oe));
    recpcs_top #(.DESC_SHORT_CYC(20), .DESC_LONG_CYC(50)) i_dut (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .phy_addr_i(PHY),
        .mgmt_clk_i(mgmt_clk), .mgmt_data_i(mgmt_line),
        .mgmt_data_o(dev_data), .mgmt_data_oe_o(dev_oe),
        .carrier_i(carrier), .rx_sym_err_i(sym_err),
        .collision_i(collision), .signal_level_i(sig_level),
        .desc_acquire_i(acquire), .desc_idle_seen_i(idle_seen),
        .ctrl_o(ctrl), .signal_detect_o(sd), .desc_locked_o(locked),
        .link_100_o(link));
    // ****************
    // access and compare tasks
    // ****************
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        i_host.frame(RECPCS_OP_WRITE, PHY, a, d, rd_val);
    endtask
    task automatic rd_chk(input string what, input logic [4:0] a,
                          input logic [15:0] exp);
        i_host.frame(RECPCS_OP_READ, PHY, a, 16'h0000, rd_val);
        chk(what, exp, rd_val);
    endtask
    task automatic carrier_ev(input int nerr, input logic col);
        tick();
        carrier = 1'h1;
        collision = col;
        repeat (nerr) begin
            tick();
            sym_err = 1'h1;
            tick();
            sym_err = 1'h0;
        end
        tick();
        carrier = 1'h0;
        collision = 1'h0;
        repeat (2) tick();
    endtask
    task automatic lock_up();
        acquire = 1'h1;
        tick();
        acquire = 1'h0;
        repeat (3) tick();
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // a hang counts as a mismatch and still reaches the report
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end
    // ****************
    // test sequence
    // ****************
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        arst_n = 1'h1;
        repeat (4) tick();
        chk("ctrl reset", 16'h0008, {9'h000, ctrl});
        rd_chk("cfg reset", CFG, 16'h0100);
        rd_chk("count reset", CNT, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            wr(CFG, 16'h0001 << bitpos[i]);
            rd_chk("cfg bit", CFG, 16'h0001 << bitpos[i]);
            chk("ctrl bit", 16'h0001 << i, {9'h000, ctrl});
            chk1("detect", i == 4, sd);
            chk1("good link", i == 1, link);
        end
        wr(CFG, 16'hEFA4);
        rd_chk("cfg reserved", CFG, 16'h0FA4);
        i_host.frame(RECPCS_OP_WRITE, PHY + 5'h01, CFG, 16'h0000, rd_val);
        i_host.frame(RECPCS_OP_READ, PHY + 5'h01, CFG, 16'h0000, rd_val);
        chk("other station", 16'hFFFF, rd_val);
        rd_chk("cfg kept", CFG, 16'h0FA4);
        carrier_ev(3, 1'h0);
        carrier_ev(2, 1'h1);
        carrier_ev(0, 1'h0);
        rd_chk("count one", CNT, 16'h0001);
        rd_chk("count cleared", CNT, 16'h0000);
        repeat (260) carrier_ev(1, 1'h0);
        wr(CNT, 16'hFFFF);
        rd_chk("count stuck", CNT, 16'h00FF);
        rd_chk("count cleared", CNT, 16'h0000);
        wr(CFG, 16'h0100);
        sig_level = 1'h1;
        lock_up();
        chk1("link up", 1'h1, link);
        repeat (40) tick();
        chk1("lock lost", 1'h0, locked);
        chk1("link kept", 1'h1, link);
        sig_level = 1'h0;
        repeat (2) tick();
        chk1("link dropped", 1'h0, link);
        wr(CFG, 16'h0000);
        sig_level = 1'h1;
        lock_up();
        repeat (4) begin
            repeat (10) tick();
            idle_seen = 1'h1;
            tick();
            idle_seen = 1'h0;
        end
        chk1("lock held", 1'h1, locked);
        chk1("link held", 1'h1, link);
        repeat (30) tick();
        chk1("link on lock loss", 1'h0, link);
        wr(CFG, 16'h0080);
        lock_up();
        repeat (30) tick();
        chk1("long lock", 1'h1, locked);
        repeat (30) tick();
        chk1("long lock lost", 1'h0, locked);
        summarize();
    end
endmodule
`default_nettype wire
